// >>> rtl/wdt_params.svh
// Register map, field positions, reset values and timing counts of the watchdog
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

`define WDT_ADDR_CLOCK_CONTROL 8'h8E
`define WDT_ADDR_UNLOCK 8'hC7
`define WDT_ADDR_WATCHDOG_CONTROL 8'hD8
`define WDT_ADDR_EXT_IRQ_ENABLE 8'hE8
`define WDT_ADDR_EXT_IRQ_PRIORITY 8'hF8

`define WDT_RST_CLOCK_CONTROL 8'h03
`define WDT_RST_WATCHDOG_CONTROL 8'h00
`define WDT_RST_EXT_IRQ 8'h00

`define WDT_BIT_INTERVAL_HI 7
`define WDT_BIT_INTERVAL_LO 6
`define WDT_BIT_COUNT_RESTART 0
`define WDT_BIT_RESET_ENABLE 1
`define WDT_BIT_RESET_CAUSE 2
`define WDT_BIT_TIMEOUT_FLAG 3
`define WDT_BIT_WDOG_IRQ 4

`define WDT_UNLOCK_FIRST 8'hAA
`define WDT_UNLOCK_SECOND 8'h55

`define WDT_IRQ_VECTOR 8'h63
`define WDT_IRQ_NATURAL_PRIO 4'hB

`define WDT_INTERVAL_0 27'h0020000
`define WDT_INTERVAL_1 27'h0100000
`define WDT_INTERVAL_2 27'h0800000
`define WDT_INTERVAL_3 27'h4000000
`define WDT_RESET_DELAY 10'h200

`endif

// >>> rtl/wdt_pkg.sv
// Types shared by the watchdog design files
package wdt_pkg;
    typedef enum logic [1:0] {
        WDT_UNLOCK_IDLE = 2'b00,
        WDT_UNLOCK_HALF = 2'b01,
        WDT_UNLOCK_OPEN = 2'b10
    } wdt_unlock_t;
    typedef logic [26:0] wdt_count_t;
endpackage

// >>> rtl/wdt_unlock.sv
// Timed-access unlock sequencer guarding writes to the watchdog control register
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_unlock (
    input wire logic clk,
    input wire logic rst,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic open
);
    wdt_pkg::wdt_unlock_t state;
    wdt_pkg::wdt_unlock_t next_state;

    assign open = (state == wdt_pkg::WDT_UNLOCK_OPEN);

    // Any write advances, restarts or cancels the sequence; an open window closes after one write
    always_comb begin
        next_state = state;
        if (sfr_wr) begin
            case (state)
                wdt_pkg::WDT_UNLOCK_IDLE: begin
                    if (sfr_addr == `WDT_ADDR_UNLOCK && sfr_wdata == `WDT_UNLOCK_FIRST) begin
                        next_state = wdt_pkg::WDT_UNLOCK_HALF;
                    end
                end
                wdt_pkg::WDT_UNLOCK_HALF: begin
                    if (sfr_addr == `WDT_ADDR_UNLOCK && sfr_wdata == `WDT_UNLOCK_SECOND) begin
                        next_state = wdt_pkg::WDT_UNLOCK_OPEN;
                    end else if (sfr_addr == `WDT_ADDR_UNLOCK
                                 && sfr_wdata == `WDT_UNLOCK_FIRST) begin
                        next_state = wdt_pkg::WDT_UNLOCK_HALF;
                    end else begin
                        next_state = wdt_pkg::WDT_UNLOCK_IDLE;
                    end
                end
                wdt_pkg::WDT_UNLOCK_OPEN: begin
                    next_state = wdt_pkg::WDT_UNLOCK_IDLE;
                end
                default: begin
                    next_state = wdt_pkg::WDT_UNLOCK_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= wdt_pkg::WDT_UNLOCK_IDLE;
        end else begin
            state <= next_state;
        end
    end
endmodule

// >>> rtl/wdt_counter.sv
// Free-running interval counter with post-expiry reset delay
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_counter (
    input wire logic clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic [1:0] interval_select,
    input wire logic reset_enable,
    output logic expire,
    output logic reset_fire
);
    wdt_pkg::wdt_count_t count;
    wdt_pkg::wdt_count_t next_count;
    logic [9:0] delay;
    logic [9:0] next_delay;
    logic armed;
    logic next_armed;
    wdt_pkg::wdt_count_t limit;

    // Interval decode
    always_comb begin
        case (interval_select)
            2'b00: limit = `WDT_INTERVAL_0;
            2'b01: limit = `WDT_INTERVAL_1;
            2'b10: limit = `WDT_INTERVAL_2;
            2'b11: limit = `WDT_INTERVAL_3;
            default: limit = `WDT_INTERVAL_0;
        endcase
    end

    // Counter advances every clk until expiry, then holds at zero while a 512-clock delay runs toward reset
    always_comb begin
        next_count = count;
        next_delay = delay;
        next_armed = armed;
        expire = 1'b0;
        reset_fire = 1'b0;
        if (restart) begin
            next_count = '0;
            next_delay = '0;
            next_armed = 1'b0;
        end else if (!armed) begin
            next_count = count + 27'h0000001;
            if (next_count >= limit) begin
                expire = 1'b1;
                next_armed = 1'b1;
                next_count = '0;
            end
        end else begin
            // Delay runs regardless of interrupt state; reset only if enabled
            next_delay = delay + 10'h001;
            if (next_delay == `WDT_RESET_DELAY) begin
                reset_fire = reset_enable;
                next_delay = '0;
                next_armed = 1'b0;
            end
        end
    end

    // State registers
    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
            delay <= '0;
            armed <= 1'b0;
        end else begin
            count <= next_count;
            delay <= next_delay;
            armed <= next_armed;
        end
    end
endmodule

// >>> rtl/wdt_top.sv
// Watchdog timer with timed-access protected control register
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    output logic wdog_irq,
    output logic wdog_irq_priority,
    output logic [7:0] wdog_irq_vector,
    output logic [3:0] wdog_irq_natural_prio,
    output logic wdog_reset
);
    logic [7:0] clock_control;
    logic [7:0] next_clock_control;
    logic [7:0] ext_irq_enable_reg;
    logic [7:0] next_ext_irq_enable_reg;
    logic [7:0] ext_irq_priority_reg;
    logic [7:0] next_ext_irq_priority_reg;
    logic reset_enable;
    logic next_reset_enable;
    logic reset_cause_flag;
    logic next_reset_cause_flag;
    logic timeout_irq_flag;
    logic next_timeout_irq_flag;
    logic count_restart;
    logic next_count_restart;
    logic wd_reset_pulse;
    logic next_wd_reset_pulse;
    logic [7:0] next_sfr_rdata;
    logic unlock_open;
    logic expire;
    logic reset_fire;
    logic ctl_write;
    logic wdog_irq_enable;
    logic [7:0] watchdog_control;

    // Unlock sequencer sees every register write
    wdt_unlock u_unlock (
        .clk(clk),
        .rst(rst),
        .sfr_wr(sfr_wr),
        .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata),
        .open(unlock_open)
    );

    // Restart pulse also fires on a watchdog reset, so counting resumes from zero
    wdt_counter u_counter (
        .clk(clk),
        .rst(rst),
        .restart(count_restart | wd_reset_pulse),
        .interval_select(clock_control[`WDT_BIT_INTERVAL_HI:`WDT_BIT_INTERVAL_LO]),
        .reset_enable(reset_enable),
        .expire(expire),
        .reset_fire(reset_fire)
    );

    // Locked writes are silently dropped; the bus gets no error indication
    assign ctl_write = sfr_wr && sfr_addr == `WDT_ADDR_WATCHDOG_CONTROL && unlock_open;
    assign wdog_irq_enable = ext_irq_enable_reg[`WDT_BIT_WDOG_IRQ];
    assign watchdog_control = {4'h0, timeout_irq_flag, reset_cause_flag,
                               reset_enable, count_restart};

    // Plain registers: clock control and the interrupt enable/priority copies
    always_comb begin
        next_clock_control = clock_control;
        next_ext_irq_enable_reg = ext_irq_enable_reg;
        next_ext_irq_priority_reg = ext_irq_priority_reg;
        if (sfr_wr) begin
            case (sfr_addr)
                `WDT_ADDR_CLOCK_CONTROL: next_clock_control = sfr_wdata;
                `WDT_ADDR_EXT_IRQ_ENABLE: next_ext_irq_enable_reg = sfr_wdata;
                `WDT_ADDR_EXT_IRQ_PRIORITY: next_ext_irq_priority_reg = sfr_wdata;
                default: next_clock_control = clock_control;
            endcase
        end
    end

    // Control bits; hardware sets win over a same-cycle software clear
    always_comb begin
        next_reset_enable = reset_enable;
        next_reset_cause_flag = reset_cause_flag;
        next_timeout_irq_flag = timeout_irq_flag;
        next_count_restart = 1'b0;
        next_wd_reset_pulse = reset_fire;
        if (ctl_write) begin
            next_reset_enable = sfr_wdata[`WDT_BIT_RESET_ENABLE];
            next_reset_cause_flag = sfr_wdata[`WDT_BIT_RESET_CAUSE];
            next_timeout_irq_flag = sfr_wdata[`WDT_BIT_TIMEOUT_FLAG];
            next_count_restart = sfr_wdata[`WDT_BIT_COUNT_RESTART];
        end
        if (expire) begin
            next_timeout_irq_flag = 1'b1;
        end
        // reset_fire is only asserted while reset_enable is set
        if (reset_fire) begin
            next_reset_cause_flag = 1'b1;
        end
    end

    // Read data is registered; unmapped and write-only addresses read zero
    always_comb begin
        next_sfr_rdata = 8'h00;
        if (sfr_rd) begin
            case (sfr_addr)
                `WDT_ADDR_CLOCK_CONTROL: next_sfr_rdata = clock_control;
                `WDT_ADDR_WATCHDOG_CONTROL: next_sfr_rdata = watchdog_control;
                `WDT_ADDR_EXT_IRQ_ENABLE: next_sfr_rdata = ext_irq_enable_reg;
                `WDT_ADDR_EXT_IRQ_PRIORITY: next_sfr_rdata = ext_irq_priority_reg;
                default: next_sfr_rdata = 8'h00;
            endcase
        end
    end

    // Address match for the core's SFR read mux
    always_comb begin
        case (sfr_addr)
            `WDT_ADDR_CLOCK_CONTROL,
            `WDT_ADDR_WATCHDOG_CONTROL,
            `WDT_ADDR_EXT_IRQ_ENABLE,
            `WDT_ADDR_EXT_IRQ_PRIORITY: sfr_hit = sfr_rd;
            default: sfr_hit = 1'b0;
        endcase
    end

    // Register all state
    always_ff @(posedge clk) begin
        if (rst) begin
            clock_control <= `WDT_RST_CLOCK_CONTROL;
            ext_irq_enable_reg <= `WDT_RST_EXT_IRQ;
            ext_irq_priority_reg <= `WDT_RST_EXT_IRQ;
            reset_enable <= 1'b0;
            reset_cause_flag <= 1'b0;
            timeout_irq_flag <= 1'b0;
            count_restart <= 1'b0;
            wd_reset_pulse <= 1'b0;
            sfr_rdata <= 8'h00;
        end else begin
            clock_control <= next_clock_control;
            ext_irq_enable_reg <= next_ext_irq_enable_reg;
            ext_irq_priority_reg <= next_ext_irq_priority_reg;
            reset_enable <= next_reset_enable;
            reset_cause_flag <= next_reset_cause_flag;
            timeout_irq_flag <= next_timeout_irq_flag;
            count_restart <= next_count_restart;
            wd_reset_pulse <= next_wd_reset_pulse;
            sfr_rdata <= next_sfr_rdata;
        end
    end

    // Interrupt is a level: flag gated by enable, whoever set the flag
    assign wdog_irq = timeout_irq_flag & wdog_irq_enable;
    assign wdog_irq_priority = ext_irq_priority_reg[`WDT_BIT_WDOG_IRQ];
    assign wdog_irq_vector = `WDT_IRQ_VECTOR;
    assign wdog_irq_natural_prio = `WDT_IRQ_NATURAL_PRIO;
    // One-cycle reset request to the chip reset controller
    assign wdog_reset = wd_reset_pulse;
endmodule

// >>> verification/wdt_top_sva.sv
// Port-level assertions for the watchdog top
`timescale 1ns/1ps
module wdt_top_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire logic wdog_irq,
    input wire logic wdog_irq_priority,
    input wire logic [7:0] wdog_irq_vector,
    input wire logic [3:0] wdog_irq_natural_prio,
    input wire logic wdog_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [31:0] up_cnt;
    logic [31:0] next_up_cnt;
    // Cycles since reset release, saturating so a long run cannot wrap it
    always_comb begin
        next_up_cnt = (up_cnt == 32'hFFFFFFFF) ? up_cnt : up_cnt + 32'h1;
        if (rst) begin
            next_up_cnt = 32'h0;
        end
    end
    always_ff @(posedge clk) begin
        up_cnt <= next_up_cnt;
    end
    a_vector_const: assert property (wdog_irq_vector == 8'h63)
        else $error("irq vector wrong");
    a_natprio_const: assert property (wdog_irq_natural_prio == 4'hB)
        else $error("natural priority wrong");
    // No watchdog reset can come before one shortest interval plus the reset delay, less 8 cycles
    a_reset_early: assert property (wdog_reset |-> up_cnt >= 32'h000201F8)
        else $error("watchdog reset too early");
    a_reset_pulse: assert property (wdog_reset |=> !wdog_reset [*8])
        else $error("watchdog reset not a single pulse");
    a_prio_follow: assert property (sfr_wr && sfr_addr == 8'hF8 |=>
        wdog_irq_priority == $past(sfr_wdata[4])) else $error("priority not taken");
    a_enable_gate: assert property (sfr_wr && sfr_addr == 8'hE8 && !sfr_wdata[4]
        |=> !wdog_irq) else $error("irq raised while disabled");
    a_irq_hold: assert property (wdog_irq && !sfr_wr |=> wdog_irq)
        else $error("irq dropped without a write");
    a_unlock_wo: assert property (sfr_rd && sfr_addr == 8'hC7 |=> sfr_rdata == 8'h00)
        else $error("unlock register readable");
    a_rdata_idle: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
        else $error("read data without a read");
endmodule
bind wdt_top wdt_top_sva i_wdt_top_sva (.clk(clk), .rst(rst), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .wdog_irq(wdog_irq), .wdog_irq_priority(wdog_irq_priority),
    .wdog_irq_vector(wdog_irq_vector), .wdog_irq_natural_prio(wdog_irq_natural_prio),
    .wdog_reset(wdog_reset));

// >>> verification/wdt_top_tb.sv
// Self-checking bench for the watchdog with a register-level model
`timescale 1ns/1ps
module wdt_top_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata, vec;
    logic sfr_hit, wdog_irq, pri, wdog_reset;
    logic [3:0] nprio;
    logic [31:0] seed = 32'h00000018;
    logic [31:0] r;
    logic [7:0] m_ck = 8'h03, m_wd = 8'h00, m_ie = 8'h00, m_ip = 8'h00;
    int n_mismatch = 0;
    int total_checks = 0;
    int ul = 0;
    int n_rst = 0;
    int cyc = 0;
    int n, t0;
    wdt_top i_wdt_top (.clk(clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit), .wdog_irq(wdog_irq), .wdog_irq_priority(pri),
        .wdog_irq_vector(vec), .wdog_irq_natural_prio(nprio), .wdog_reset(wdog_reset));
    always #2.5 clk = ~clk;
    // Cycle count and watchdog reset pulses seen
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wdog_reset === 1'b1) n_rst <= n_rst + 1;
    end
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // One write strobe, then the model of unlock state and stored registers
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'b0;
        // Let the edge that took the write settle before anyone looks at outputs
        #1;
        if (ul == 2) begin
            if (a == 8'hD8) m_wd = d & 8'h0E;
            ul = 0;
        end else if (a == 8'hC7 && d == 8'hAA) ul = 1;
        else if (a == 8'hC7 && d == 8'h55 && ul == 1) ul = 2;
        else ul = 0;
        if (a == 8'h8E) m_ck = d;
        if (a == 8'hE8) m_ie = d;
        if (a == 8'hF8) m_ip = d;
    endtask
    task automatic unlock();
        wr(8'hC7, 8'hAA);
        wr(8'hC7, 8'h55);
    endtask
    // Idle cycle first so a self-clearing restart bit has settled
    task automatic rd(logic [7:0] a, logic [7:0] m);
        logic [7:0] e;
        case (a)
            8'h8E: e = m_ck;
            8'hD8: e = m_wd;
            8'hE8: e = m_ie;
            8'hF8: e = m_ip;
            default: e = 8'h00;
        endcase
        @(posedge clk);
        @(posedge clk);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        #1;
        if (a != 8'hC7) chk("hit", sfr_hit, a inside {8'h8E, 8'hD8, 8'hE8, 8'hF8});
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1;
        chk("rdata", sfr_rdata & m, e & m);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Hang guard sized about one and a half shortest intervals
    initial begin
        repeat (200000) @(posedge clk);
        n_mismatch++;
        $display("watchdog of the bench expired");
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        chk("vector", vec, 8'h63);
        chk("nprio", nprio, 4'hB);
        rd(8'h8E, 8'hC7);
        rd(8'hD8, 8'h0F);
        rd(8'hC7, 8'hFF);
        rd(8'h10, 8'hFF);
        $display("test reset values done");
        // Locked, broken and already-used unlock windows all refuse the write
        wr(8'hD8, 8'h0E);
        wr(8'hC7, 8'hAA);
        wr(8'h8E, 8'h03);
        wr(8'hC7, 8'h55);
        wr(8'hD8, 8'h0E);
        unlock();
        wr(8'hE8, 8'h00);
        wr(8'hD8, 8'h0E);
        rd(8'hD8, 8'h0F);
        $display("test lock done");
        // Software sets flag and cause: interrupt yes, reset no
        unlock();
        wr(8'hD8, 8'h0E);
        wr(8'hE8, 8'h10);
        rd(8'hD8, 8'h0F);
        chk("irq on", wdog_irq, 1'b1);
        chk("no reset", n_rst, 0);
        wr(8'hE8, 8'h00);
        chk("irq masked", wdog_irq, 1'b0);
        wr(8'hE8, 8'h10);
        unlock();
        wr(8'hD8, 8'h01);
        rd(8'hD8, 8'h0F);
        chk("irq cleared", wdog_irq, 1'b0);
        $display("test software flags done");
        // Random register contents read back
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            wr(8'hF8, r[7:0]);
            wr(8'hE8, r[15:8]);
            wr(8'h8E, r[23:16]);
            rd(8'hF8, 8'hFF);
            rd(8'hE8, 8'hFF);
            rd(8'h8E, 8'hC7);
            chk("prio", pri, r[4]);
        end
        $display("test random registers done");
        // Expiry at code 00, then reset 512 clocks later and counting resumes
        wr(8'h8E, 8'h03);
        wr(8'hE8, 8'h10);
        unlock();
        wr(8'hD8, 8'h03);
        t0 = cyc;
        n = 0;
        while (wdog_irq !== 1'b1 && n < 140000) begin
            @(posedge clk);
            n++;
        end
        chk("expiry", cyc - t0 > 131064 && cyc - t0 < 131080, 1);
        t0 = cyc;
        n = 0;
        while (wdog_reset !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
        chk("delay", cyc - t0 >= 510 && cyc - t0 <= 514, 1);
        m_wd = 8'h0E;
        rd(8'hD8, 8'h0F);
        repeat (1000) @(posedge clk);
        chk("one reset", n_rst, 1);
        chk("irq held", wdog_irq, 1'b1);
        $display("test timeout done");
        wrap_up();
    end
endmodule
